// [include/pcc_pkg.sv]
// Purpose: Constants and carriers for the configuration identity/command/status bank
// Assumes: 32-bit configuration accesses with byte enables, one clock
// Notes:   Event inputs are single-cycle pulses from the bus engines
// Notes on behaviour
// (R1) Detected-parity flag sets on master data or target address/data parity error.
// (R2) System-error flag sets when SERR# driven; SERR# only while enable set.
// (R3) Received-master-abort flag sets when own master transaction master-aborts.
// (R4) Received-target-abort flag sets when own master transaction is target-aborted.
// (R5) Signaled-target-abort flag sets when own target issues target-abort.
// (R6) Devsel timing field reads medium, and claims use medium timing.
// (R7) Master data-parity flag sets on PERR# by us or target, if response on.
// (R8) Target back-to-back capable bit reads one; target accepts such cycles.
// (R9) High-speed capable bit reads zero; 33 MHz operation only.
// (R10) Capability list bit reads one; capabilities pointer provided in config space; here only on the cap_pointer port, config reads of other offsets give zero.
// (R11) Master back-to-back bit reads zero; master never issues such cycles.
// (R12) System-error enable read-write, resets zero, gates SERR# with parity response.
// (R13) Wait-cycle bit reads zero; no address or data stepping.
// (R14) Parity-response bit read-write, resets zero, enables PERR# and master flag.
// (R15) Bus parity is always generated regardless of parity response.
// (R16) Identity register: device id high half, vendor id low, global reset.
// (R17) Memory and I/O accesses accepted only while their enables set; reset zero.
// (R18) Bus mastership only while bus-master enable set; reset value by strap.
// (R19) Software writes one only to flags to clear; zero leaves flags alone.
package pcc_pkg;
  localparam logic [11:0] OFF_IDENTITY = 12'h000;
  localparam logic [11:0] OFF_CMD_STAT = 12'h004;
  localparam logic [7:0]  CAP_POINTER  = 8'h34;
  localparam logic [1:0]  DEVSEL_MED   = 2'h1;
  // Edges after reset release until the synchronised strap is valid
  localparam logic [1:0]  STRAP_LOAD_AGE = 2'h2;
  localparam int BIT_DPE  = 31;
  localparam int BIT_SSE  = 30;
  localparam int BIT_RMA  = 29;
  localparam int BIT_RTA  = 28;
  localparam int BIT_STA  = 27;
  localparam int BIT_DEVS = 25;
  localparam int BIT_MDP  = 24;
  localparam int BIT_TBB  = 23;
  localparam int BIT_HSC  = 21;
  localparam int BIT_CAPL = 20;
  localparam int BIT_MBB  = 9;
  localparam int BIT_SEE  = 8;
  localparam int BIT_WAIT = 7;
  localparam int BIT_PRE  = 6;
  localparam int BIT_BME  = 2;
  localparam int BIT_MSE  = 1;
  localparam int BIT_IOE  = 0;
  localparam logic [15:0] RST_DEVICE_ID = 16'h0a5a; // Arbitrary value
  localparam logic [15:0] RST_VENDOR_ID = 16'h5a0a; // Arbitrary value

  typedef struct packed {
    logic master_data_perr;
    logic target_addr_perr;
    logic target_data_perr;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
    logic perr_by_target;
  } pcc_events_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcc_cfg_req_t;
endpackage

// [verilog/pcc_config_regs.sv]
// Purpose: Configuration header identity and command/status registers
// Assumes: Event and request inputs come from same-clock logic; strap from pin
// Notes:   Writes to the identity word load new ids; global reset restores them
`timescale 1ns/1ps
`default_nettype none
module pcc_config_regs (
  // Clock and resets
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  pci_rst_n,
  // Strap for bus-master enable reset value
  input  wire logic                  bm_strap,
  // Configuration access
  input  wire pcc_pkg::pcc_cfg_req_t req,
  output var  logic [31:0]           rdata,
  output var  logic                  rvalid,
  // Bus events
  input  wire pcc_pkg::pcc_events_t  ev,
  input  wire logic                  data_perr_seen,
  // Controls to bus engines
  output var  logic                  perr_drive,
  output var  logic                  serr_drive,
  output var  logic                  mem_access_ok,
  output var  logic                  io_access_ok,
  output var  logic                  master_allowed,
  output var  logic [1:0]            devsel_timing,
  output var  logic [7:0]            cap_pointer
);
  logic [15:0] device_id, vendor_identifier;
  logic [15:0] next_device_id, next_vendor_identifier;
  logic        detected_parity_flag, signaled_system_error_flag;
  logic        received_master_abort_flag, received_target_abort_flag;
  logic        signaled_target_abort_flag, master_data_parity_flag;
  logic        system_error_enable, parity_response_enable;
  logic        bus_master_enable, memory_space_enable, io_space_enable;
  logic        next_dpe, next_sse, next_rma, next_rta, next_sta, next_mdp;
  logic        next_see, next_pre, next_bme, next_mse, next_ioe;
  logic        strap_s1, strap_s2;
  logic [1:0]  strap_age, next_strap_age;
  logic [31:0] cs_word, next_rdata;
  logic        id_hit, cs_hit, serr_now;
  logic [31:0] wmask;

  assign id_hit = req.addr == pcc_pkg::OFF_IDENTITY;
  assign cs_hit = req.addr == pcc_pkg::OFF_CMD_STAT;
  assign wmask  = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}};
  // Address parity reported only with both enables set
  assign serr_now = ev.target_addr_perr & system_error_enable & parity_response_enable; // R2 R12

  always_comb begin
    cs_word = '0;
    cs_word[pcc_pkg::BIT_DPE]  = detected_parity_flag;
    cs_word[pcc_pkg::BIT_SSE]  = signaled_system_error_flag;
    cs_word[pcc_pkg::BIT_RMA]  = received_master_abort_flag;
    cs_word[pcc_pkg::BIT_RTA]  = received_target_abort_flag;
    cs_word[pcc_pkg::BIT_STA]  = signaled_target_abort_flag;
    cs_word[pcc_pkg::BIT_DEVS +: 2] = pcc_pkg::DEVSEL_MED; // R6
    cs_word[pcc_pkg::BIT_MDP]  = master_data_parity_flag;
    cs_word[pcc_pkg::BIT_TBB]  = 1'b1; // R8
    cs_word[pcc_pkg::BIT_HSC]  = 1'b0; // R9
    cs_word[pcc_pkg::BIT_CAPL] = 1'b1; // R10
    cs_word[pcc_pkg::BIT_MBB]  = 1'b0; // R11
    cs_word[pcc_pkg::BIT_SEE]  = system_error_enable;
    cs_word[pcc_pkg::BIT_WAIT] = 1'b0; // R13
    cs_word[pcc_pkg::BIT_PRE]  = parity_response_enable;
    cs_word[pcc_pkg::BIT_BME]  = bus_master_enable;
    cs_word[pcc_pkg::BIT_MSE]  = memory_space_enable;
    cs_word[pcc_pkg::BIT_IOE]  = io_space_enable;
  end

  // Identity word, global reset domain
  always_comb begin
    next_device_id = device_id;
    next_vendor_identifier = vendor_identifier;
    if (req.wr && id_hit) begin // R16
      next_device_id = (device_id & ~wmask[31:16]) | (req.wdata[31:16] & wmask[31:16]);
      next_vendor_identifier = (vendor_identifier & ~wmask[15:0])
                               | (req.wdata[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      device_id         <= pcc_pkg::RST_DEVICE_ID; // R16
      vendor_identifier <= pcc_pkg::RST_VENDOR_ID;
    end else begin
      device_id         <= next_device_id;
      vendor_identifier <= next_vendor_identifier;
    end
  end

  // Status flags: a set in the same cycle as a clear wins
  always_comb begin
    logic clr_ok;
    logic [31:0] c;
    clr_ok = req.wr && cs_hit;
    c = clr_ok ? (req.wdata & wmask) : 32'h0; // R19
    next_dpe = (detected_parity_flag & ~c[pcc_pkg::BIT_DPE])
             | ev.master_data_perr | ev.target_addr_perr | ev.target_data_perr; // R1
    next_sse = (signaled_system_error_flag & ~c[pcc_pkg::BIT_SSE]) | serr_now; // R2
    next_rma = (received_master_abort_flag & ~c[pcc_pkg::BIT_RMA]) | ev.master_abort; // R3
    next_rta = (received_target_abort_flag & ~c[pcc_pkg::BIT_RTA])
             | ev.target_abort_rcvd; // R4
    next_sta = (signaled_target_abort_flag & ~c[pcc_pkg::BIT_STA])
             | ev.target_abort_sent; // R5
    next_mdp = (master_data_parity_flag & ~c[pcc_pkg::BIT_MDP])
             | (parity_response_enable & (ev.master_data_perr | ev.perr_by_target)); // R7 R14
    next_see = system_error_enable;
    next_pre = parity_response_enable;
    // Strap is only trusted once it has crossed both synchroniser stages
    next_strap_age = (strap_age == 2'h3) ? strap_age : strap_age + 2'h1;
    next_bme = (strap_age == pcc_pkg::STRAP_LOAD_AGE) ? strap_s2 : bus_master_enable; // R18
    next_mse = memory_space_enable;
    next_ioe = io_space_enable;
    if (clr_ok && req.be[1]) begin
      next_see = req.wdata[pcc_pkg::BIT_SEE]; // R12
    end
    if (clr_ok && req.be[0]) begin
      next_pre = req.wdata[pcc_pkg::BIT_PRE]; // R14
      next_bme = req.wdata[pcc_pkg::BIT_BME]; // R18
      next_mse = req.wdata[pcc_pkg::BIT_MSE]; // R17
      next_ioe = req.wdata[pcc_pkg::BIT_IOE];
    end
  end

  // Strap passes a synchroniser, then is caught once after reset release
  always_ff @(posedge clk or negedge pci_rst_n) begin
    if (!pci_rst_n) begin
      strap_s1    <= 1'b0;
      strap_s2    <= 1'b0;
      strap_age   <= 2'h0;
      detected_parity_flag       <= 1'b0;
      signaled_system_error_flag <= 1'b0;
      received_master_abort_flag <= 1'b0;
      received_target_abort_flag <= 1'b0;
      signaled_target_abort_flag <= 1'b0;
      master_data_parity_flag    <= 1'b0;
      system_error_enable        <= 1'b0;
      parity_response_enable     <= 1'b0;
      bus_master_enable          <= 1'b0;
      memory_space_enable        <= 1'b0;
      io_space_enable            <= 1'b0;
    end else begin
      strap_s1    <= bm_strap;
      strap_s2    <= strap_s1;
      strap_age   <= next_strap_age;
      detected_parity_flag       <= next_dpe;
      signaled_system_error_flag <= next_sse;
      received_master_abort_flag <= next_rma;
      received_target_abort_flag <= next_rta;
      signaled_target_abort_flag <= next_sta;
      master_data_parity_flag    <= next_mdp;
      system_error_enable        <= next_see;
      parity_response_enable     <= next_pre;
      bus_master_enable          <= next_bme;
      memory_space_enable        <= next_mse;
      io_space_enable            <= next_ioe;
    end
  end

  // Read port: unmapped offsets read zero
  always_comb begin
    next_rdata = rdata;
    if (req.rd) begin
      if (id_hit) begin
        next_rdata = {device_id, vendor_identifier};
      end else if (cs_hit) begin
        next_rdata = cs_word;
      end else begin
        next_rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata          <= 32'h0;
      rvalid         <= 1'b0;
      perr_drive     <= 1'b0;
      serr_drive     <= 1'b0;
      mem_access_ok  <= 1'b0;
      io_access_ok   <= 1'b0;
      master_allowed <= 1'b0;
      devsel_timing  <= pcc_pkg::DEVSEL_MED;
      cap_pointer    <= pcc_pkg::CAP_POINTER;
    end else begin
      rdata          <= next_rdata;
      rvalid         <= req.rd;
      perr_drive     <= data_perr_seen & parity_response_enable; // R14
      serr_drive     <= serr_now; // R2
      mem_access_ok  <= next_mse; // R17
      io_access_ok   <= next_ioe; // R17
      master_allowed <= next_bme; // R18 R11 R13
      devsel_timing  <= pcc_pkg::DEVSEL_MED; // R6 R8
      cap_pointer    <= pcc_pkg::CAP_POINTER; // R10 R9 R15
    end
  end

  // Checks
  a_serr_gated: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n)
    serr_drive |-> $past(system_error_enable) && $past(parity_response_enable)) // R2
    else $error("SERR driven while disabled");
  a_serr_flag: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n)
    serr_drive |-> signaled_system_error_flag) // R2
    else $error("system error flag not set with SERR");
  a_dpe_set: assert property (@(posedge clk) disable iff (!pci_rst_n)
    (ev.master_data_perr || ev.target_addr_perr || ev.target_data_perr)
    |=> detected_parity_flag) // R1
    else $error("detected parity flag missed");
  a_rma_set: assert property (@(posedge clk) disable iff (!pci_rst_n)
    ev.master_abort |=> received_master_abort_flag) // R3
    else $error("master abort flag missed");
  a_rta_set: assert property (@(posedge clk) disable iff (!pci_rst_n)
    ev.target_abort_rcvd |=> received_target_abort_flag) // R4
    else $error("received target abort flag missed");
  a_sta_set: assert property (@(posedge clk) disable iff (!pci_rst_n)
    ev.target_abort_sent |=> signaled_target_abort_flag) // R5
    else $error("signaled target abort flag missed");
  a_mdp_gate: assert property (@(posedge clk) disable iff (!pci_rst_n)
    $rose(master_data_parity_flag) |-> $past(parity_response_enable)) // R7
    else $error("master parity flag set without response");
  a_flag_hold: assert property (@(posedge clk) disable iff (!pci_rst_n)
    (req.wr && cs_hit && req.be[3] && !req.wdata[pcc_pkg::BIT_RMA] && received_master_abort_flag)
    |=> received_master_abort_flag) // R19
    else $error("zero write cleared a flag");
  a_cs_fixed: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n) // R6
    rvalid && $past(req.rd && cs_hit) |-> rdata[26:25] == 2'h1 && rdata[23] == 1'h1
    && rdata[21] == 1'h0 && rdata[20] == 1'h1 && rdata[9] == 1'h0
    && rdata[7] == 1'h0) // R8 R9 R10 R11 R13
    else $error("fixed status fields wrong");
  a_mem_gate: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n)
    mem_access_ok == memory_space_enable) // R17
    else $error("memory access gate out of step");
  a_perr_gate: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n)
    perr_drive |-> $past(parity_response_enable)) // R14
    else $error("PERR driven without response enable");

  // Flags rise only for a cause seen on the previous edge; the master parity flag must rise on its cause
  a_dpe_cause: assert property (@(posedge clk) disable iff (!pci_rst_n) // R1
    $rose(detected_parity_flag)
    |-> $past(ev.master_data_perr || ev.target_addr_perr || ev.target_data_perr))
    else $error("detected parity flag set without cause");
  a_sse_cause: assert property (@(posedge clk) disable iff (!pci_rst_n) // R2
    $rose(signaled_system_error_flag)
    |-> $past(serr_now))
    else $error("system error flag set without SERR");
  a_rma_cause: assert property (@(posedge clk) disable iff (!pci_rst_n) // R3
    $rose(received_master_abort_flag)
    |-> $past(ev.master_abort))
    else $error("master abort flag set without cause");
  a_rta_cause: assert property (@(posedge clk) disable iff (!pci_rst_n) // R4
    $rose(received_target_abort_flag)
    |-> $past(ev.target_abort_rcvd))
    else $error("received target abort flag set without cause");
  a_sta_cause: assert property (@(posedge clk) disable iff (!pci_rst_n) // R5
    $rose(signaled_target_abort_flag)
    |-> $past(ev.target_abort_sent))
    else $error("signaled target abort flag set without cause");
  a_mdp_set: assert property (@(posedge clk) disable iff (!pci_rst_n) // R7
    parity_response_enable && (ev.master_data_perr || ev.perr_by_target)
    |=> master_data_parity_flag)
    else $error("master parity flag missed");

  // A one clears, unless an event lands on the same edge
  a_flag_clear: assert property (@(posedge clk) disable iff (!pci_rst_n) // R19
    req.wr && cs_hit && req.be[3] && req.wdata[pcc_pkg::BIT_RMA] && !ev.master_abort
    |=> !received_master_abort_flag)
    else $error("one write did not clear flag");

  // Enable bits follow their byte lane; bus-master enable takes the strap once
  a_see_write: assert property (@(posedge clk) disable iff (!pci_rst_n) // R12
    req.wr && cs_hit && req.be[1]
    |=> system_error_enable == $past(req.wdata[pcc_pkg::BIT_SEE]))
    else $error("system error enable not written");
  a_pre_write: assert property (@(posedge clk) disable iff (!pci_rst_n) // R14
    req.wr && cs_hit && req.be[0]
    |=> parity_response_enable == $past(req.wdata[pcc_pkg::BIT_PRE]))
    else $error("parity response enable not written");
  a_strap_load: assert property (@(posedge clk) disable iff (!pci_rst_n) // R18
    strap_age == pcc_pkg::STRAP_LOAD_AGE && !(req.wr && cs_hit && req.be[0])
    |=> bus_master_enable == $past(strap_s2))
    else $error("bus master enable missed the strap");

  // Bus-side drives
  a_serr_pulse: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n) // R12
    ev.target_addr_perr && system_error_enable && parity_response_enable
    |=> serr_drive)
    else $error("SERR not driven on address parity error");
  a_perr_pulse: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n) // R14
    data_perr_seen && parity_response_enable
    |=> perr_drive)
    else $error("PERR not driven on data parity error");
  a_io_gate: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n) // R17
    io_access_ok == io_space_enable)
    else $error("io access gate out of step");
  a_master_gate: assert property (@(posedge clk) disable iff (!pci_rst_n || !rst_n) // R18
    master_allowed == bus_master_enable)
    else $error("master gate out of step");
  a_devsel_fixed: assert property (@(posedge clk) disable iff (!rst_n) // R6
    devsel_timing == pcc_pkg::DEVSEL_MED)
    else $error("devsel timing not medium");
  a_cap_fixed: assert property (@(posedge clk) disable iff (!rst_n) // R10
    cap_pointer == pcc_pkg::CAP_POINTER)
    else $error("capability pointer wrong");

  // Read port and identity word
  a_id_read: assert property (@(posedge clk) disable iff (!rst_n) // R16
    rvalid && $past(req.rd && id_hit)
    |-> rdata == $past({device_id, vendor_identifier}))
    else $error("identity read wrong");
  a_id_write: assert property (@(posedge clk) disable iff (!rst_n) // R16
    req.wr && id_hit && req.be == 4'hf
    |=> {device_id, vendor_identifier} == $past(req.wdata))
    else $error("identity write lost");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rvalid && $past(req.rd && !id_hit && !cs_hit)
    |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    rvalid == $past(req.rd))
    else $error("read valid out of step");

  c_serr: cover property (@(posedge clk) serr_drive);
  c_strap: cover property (@(posedge clk) strap_age == pcc_pkg::STRAP_LOAD_AGE && strap_s2);
  c_clear: cover property (@(posedge clk) received_master_abort_flag ##1 !received_master_abort_flag);
  c_set_clr: cover property (@(posedge clk) req.wr && cs_hit && ev.master_abort);
  c_id_read: cover property (@(posedge clk) req.rd && id_hit ##1 rvalid);
endmodule // pcc_config_regs
`default_nettype wire

// [dv/pcc_bus_agent.sv]
// Purpose: Bus-side agent that raises parity and abort events
// Assumes: Events are one-cycle pulses launched just after a clock edge
// Notes:   Outputs idle low so no stale event is counted twice
`timescale 1ns/1ps
`default_nettype none
module pcc_bus_agent (
  // Clock
  input  wire logic                 clk,
  // Events toward the register bank
  output var  pcc_pkg::pcc_events_t ev,
  output var  logic                 data_perr_seen
);
  initial begin
    ev = '0;
    data_perr_seen = 1'b0;
  end

  // Index 0..6 picks one event bit, 7 a data parity error for PERR#
  task automatic fire(input int idx);
    @(posedge clk);
    #1;
    if (idx < 7) ev = pcc_pkg::pcc_events_t'(7'h01 << idx);
    else data_perr_seen = 1'b1;
    @(posedge clk);
    #1;
    ev = '0;
    data_perr_seen = 1'b0;
  endtask
endmodule // pcc_bus_agent
`default_nettype wire

// [dv/tb_pcc_config_regs.sv]
// Purpose: Self-checking bench for the identity and command/status bank
// Assumes: Strap tied high, so bus-master enable comes up set
// Notes:   Expected words are built from fixed field positions
`timescale 1ns/1ps
`default_nettype none
module tb_pcc_config_regs;
  localparam logic [31:0] BASE = 32'h0290_0004;
  localparam logic [31:0] EN   = 32'h0000_0147;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  pci_rst_n = 1'b0;
  pcc_pkg::pcc_cfg_req_t req = '0;
  pcc_pkg::pcc_events_t  ev;
  logic                  data_perr_seen;
  logic [31:0]           rdata;
  logic                  rvalid, perr_drive, serr_drive, mem_ok, io_ok, mst_ok;
  logic [1:0]            devsel_timing;
  logic [7:0]            cap_pointer;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  logic [31:0]           mask [7] = '{32'h0100_0000, 32'h0800_0000, 32'h1000_0000,
                                      32'h2000_0000, 32'h8000_0000, 32'hc000_0000,
                                      32'h8100_0000};

  always #5 clk = ~clk;

  pcc_config_regs u_dut (.clk(clk), .rst_n(rst_n), .pci_rst_n(pci_rst_n), .bm_strap(1'b1),
    .req(req), .rdata(rdata), .rvalid(rvalid), .ev(ev), .data_perr_seen(data_perr_seen),
    .perr_drive(perr_drive), .serr_drive(serr_drive), .mem_access_ok(mem_ok),
    .io_access_ok(io_ok), .master_allowed(mst_ok), .devsel_timing(devsel_timing),
    .cap_pointer(cap_pointer));
  pcc_bus_agent u_agent (.clk(clk), .ev(ev), .data_perr_seen(data_perr_seen));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  // Read data is taken in the cycle rvalid stands, bounded wait
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    int k;
    @(posedge clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
    @(posedge clk);
    #1;
    req = '0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 4) begin
      error_cnt++;
      complete_run();
    end else begin
      chk(rdata, exp);
    end
  endtask

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    pci_rst_n = 1'b1;
    repeat (4) @(posedge clk);
    rd(pcc_pkg::OFF_IDENTITY, {pcc_pkg::RST_DEVICE_ID, pcc_pkg::RST_VENDOR_ID});
    rd(pcc_pkg::OFF_CMD_STAT, BASE);
    chk(32'(devsel_timing), 32'h1);
    chk(32'(cap_pointer), 32'h34);
    chk(32'({mem_ok, io_ok, mst_ok}), 32'h1);
    rd(12'h008, 32'h0);
    $display("test reset done");
    wr(pcc_pkg::OFF_CMD_STAT, 4'hf, 32'hffff_ffff);
    rd(pcc_pkg::OFF_CMD_STAT, BASE | EN);
    chk(32'({mem_ok, io_ok, mst_ok}), 32'h7);
    $display("test enables done");
    for (int i = 0; i < 7; i++) begin
      u_agent.fire(i);
      if (i == 5) chk(32'(serr_drive), 32'h1);
      rd(pcc_pkg::OFF_CMD_STAT, BASE | EN | mask[i]);
      wr(pcc_pkg::OFF_CMD_STAT, 4'hf, EN);
      rd(pcc_pkg::OFF_CMD_STAT, BASE | EN | mask[i]);
      wr(pcc_pkg::OFF_CMD_STAT, 4'hf, EN | mask[i]);
      rd(pcc_pkg::OFF_CMD_STAT, BASE | EN);
    end
    u_agent.fire(7);
    chk(32'(perr_drive), 32'h1);
    $display("test events done");
    wr(pcc_pkg::OFF_CMD_STAT, 4'hf, 32'h0);
    chk(32'({mem_ok, io_ok, mst_ok}), 32'h0);
    u_agent.fire(5);
    chk(32'(serr_drive), 32'h0);
    u_agent.fire(0);
    u_agent.fire(7);
    chk(32'(perr_drive), 32'h0);
    rd(pcc_pkg::OFF_CMD_STAT, 32'h8290_0000);
    $display("test disabled done");
    wr(pcc_pkg::OFF_IDENTITY, 4'hf, 32'h1234_5678);
    rd(pcc_pkg::OFF_IDENTITY, 32'h1234_5678);
    #1;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd(pcc_pkg::OFF_IDENTITY, {pcc_pkg::RST_DEVICE_ID, pcc_pkg::RST_VENDOR_ID});
    $display("test identity done");
    complete_run();
  end
endmodule // tb_pcc_config_regs
`default_nettype wire
